// >>> cca_pkg.sv
// Constants, register map, field layout and carrier types of the counter array.
// Assumes an 8-bit register port and a 125 MHz ref_clk used as the oscillator.
package cca_pkg;

  // ----------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------
  localparam int ADDR_W  = 6;   // Register address width
  localparam int DATA_W  = 8;   // Register data width
  localparam int CNT_W   = 16;  // Time base and capture width
  localparam int NUM_MOD = 5;   // Capture/compare modules
  localparam int PORT_W  = 8;   // Port-1 width

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] OFF_CTRL_FLAGS = 6'h00;  // array_control_flags
  localparam logic [ADDR_W-1:0] OFF_CNT_MODE   = 6'h01;  // array_counter_mode
  localparam logic [ADDR_W-1:0] OFF_CNT_LOW    = 6'h02;  // Counter low byte
  localparam logic [ADDR_W-1:0] OFF_CNT_HIGH   = 6'h03;  // Counter high byte
  localparam int                OFF_MM_BASE    = 16;     // module_mode_n, n = 0..4
  localparam int                OFF_CAPL_BASE  = 24;     // module_capture_low_n
  localparam int                OFF_CAPH_BASE  = 32;     // module_capture_high_n

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int CTRL_OVF_BIT  = 7;  // overflow_flag
  localparam int CTRL_RUN_BIT  = 6;  // run_control_bit
  localparam int MODE_IDLE_BIT = 7;  // idle_stop_bit
  localparam int MODE_WDT_BIT  = 6;  // watchdog_enable_bit
  localparam int MODE_SRC_HI   = 2;  // count_source_sel_hi
  localparam int MODE_SRC_LO   = 1;  // count_source_sel_lo
  localparam int MODE_OVF_IE   = 0;  // overflow_irq_enable
  localparam int MM_IRQ_EN     = 0;  // module_irq_enable
  localparam int MM_PWM        = 1;  // Pulse width modulation mode
  localparam int MM_TOGGLE     = 2;  // toggle_on_match
  localparam int MM_MATCH      = 3;  // flag_on_match
  localparam int MM_CAP_FALL   = 4;  // capture_falling_enable
  localparam int MM_CAP_RISE   = 5;  // capture_rising_enable
  localparam int MM_COMP_EN    = 6;  // comparator_enable

  // ----------------------------------------------------------------
  // Pins, reset values, dividers
  // ----------------------------------------------------------------
  localparam int                 PIN_EXT_COUNT = 2;  // external_count_input
  localparam int                 PIN_MOD_BASE  = 3;  // module_pin of module 0
  localparam int                 WDT_MOD       = 4;  // Module with watchdog duty
  localparam logic [DATA_W-1:0]  RST_REG       = 8'h00;
  localparam logic               RST_PIN       = 1'b1;    // Port latches idle high
  localparam logic [CNT_W-1:0]   CNT_MAX       = 16'hFFFF;
  localparam logic [7:0]         LOW_MAX       = 8'hFF;
  localparam logic [3:0]         DIV_SLOW_6    = 4'h6;
  localparam logic [3:0]         DIV_SLOW_12   = 4'hC;
  localparam logic [3:0]         DIV_FAST_6    = 4'h2;
  localparam logic [3:0]         DIV_FAST_12   = 4'h4;

  // Count source selection
  typedef enum logic [1:0] {
    CCA_SRC_OSC_SLOW = 2'b00,
    CCA_SRC_OSC_FAST = 2'b01,
    CCA_SRC_T0_OVF   = 2'b10,
    CCA_SRC_EXT_PIN  = 2'b11
  } cca_src_e;

  // Register port request
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic              wr;
    logic              rd;
  } cca_bus_s;

endpackage

// >>> cca_top.sv
// Counter array: shared 16-bit time base with five capture/compare modules.
// Assumes inputs synchronous to ref_clk except port-1 pins, which are synchronised here.
//
// Overview of operation
// - One shared 16-bit counter for five modules
// - Modules capture, time, toggle out or PWM
// - Module n owns port-1 bit three plus n
// - Source select picks oscillator, timer0, pin
// - Idle-stop bit halts counter during idle
// - Watchdog enable bit governs module four
// - Run bit starts and stops counting
// - Overflow sets flag, irq when enabled
// - Overflow flag cleared only by software
// - Per-module flags set on match/capture
// - Module flags cleared only by software
// - Mode bit zero enables module interrupt
// - Mode bit one selects PWM
// - Mode bit two toggles pin on match
// - Mode bit three flags on match
// - Bits four/five pick capture edges
// - Mode bit six enables comparator
// - Byte pair holds capture or compare value
// - PWM duty set by capture pair
//
// Added by the designer: the address map and strobed register access.
`timescale 1ns/1ps
module cca_top
(
  // Clock and reset
  input  wire logic                        ref_clk,
  input  wire logic                        arst_n,
  // Register port
  input  wire cca_pkg::cca_bus_s           bus_req,
  output logic [cca_pkg::DATA_W-1:0]       bus_rdata,
  // Processor context
  input  wire logic                        cpu_idle,
  input  wire logic                        clk_mode_12,
  input  wire logic                        timer0_ovf,
  // Port-1 pins
  input  wire logic [cca_pkg::PORT_W-1:0]  p1_in,
  output logic [cca_pkg::PORT_W-1:0]       p1_out,
  output logic [cca_pkg::PORT_W-1:0]       p1_oe,
  // Requests
  output logic                             irq,
  output logic                             watchdog_enable,
  output logic                             watchdog_trip
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic [cca_pkg::CNT_W-1:0]   cnt_ff;          // Time base
  logic [cca_pkg::CNT_W-1:0]   nxt_cnt;         // Value after one count
  logic [3:0]                  presc_ff;        // Oscillator divider
  logic [3:0]                  div_sel;         // Current divide ratio
  logic                        osc_tick;        // Divider wrap
  logic                        ext_s1_ff;       // External count sync stage 1
  logic                        ext_s2_ff;       // External count sync stage 2
  logic                        ext_s3_ff;       // Edge history
  logic                        ext_tick;        // External count edge
  logic                        src_tick;        // Selected source event
  logic                        count_en;        // Counter allowed to run
  logic                        tick;            // Counter advances this cycle
  logic                        ovf_set;         // Overflow this cycle
  logic                        ovf_flag_ff;     // overflow_flag
  logic                        run_ff;          // run_control_bit
  logic [cca_pkg::NUM_MOD-1:0] mod_flag_ff;     // module_event_flag per module
  logic [cca_pkg::NUM_MOD-1:0] mod_evt;         // Module events this cycle
  logic [cca_pkg::NUM_MOD-1:0] mod_match;       // Comparator matches
  logic [cca_pkg::NUM_MOD-1:0] mod_irq_en;      // module_irq_enable per module
  logic [cca_pkg::DATA_W-1:0]  cnt_mode_ff;     // array_counter_mode
  logic [cca_pkg::DATA_W-1:0]  mm_ff  [cca_pkg::NUM_MOD];  // module_mode_n
  logic [cca_pkg::DATA_W-1:0]  capl_ff[cca_pkg::NUM_MOD];  // module_capture_low_n
  logic [cca_pkg::DATA_W-1:0]  caph_ff[cca_pkg::NUM_MOD];  // module_capture_high_n
  logic [cca_pkg::NUM_MOD-1:0] pin_ff;          // Module pin output latches
  logic [cca_pkg::NUM_MOD-1:0] pin_drive;       // Module drives its pin
  logic [cca_pkg::DATA_W-1:0]  nxt_rdata;       // Read mux
  logic [cca_pkg::DATA_W-1:0]  rdata_ff;        // Registered read data
  logic                        irq_ff;          // Registered request
  logic                        wdt_trip_ff;     // Watchdog pulse
  logic                        wr_ctrl;         // Write decode
  logic                        wr_cmode;
  logic                        wr_cntl;
  logic                        wr_cnth;
  cca_pkg::cca_src_e           src_sel;         // Count source

  // Write decodes
  assign wr_ctrl  = bus_req.wr && (bus_req.addr == cca_pkg::OFF_CTRL_FLAGS);
  assign wr_cmode = bus_req.wr && (bus_req.addr == cca_pkg::OFF_CNT_MODE);
  assign wr_cntl  = bus_req.wr && (bus_req.addr == cca_pkg::OFF_CNT_LOW);
  assign wr_cnth  = bus_req.wr && (bus_req.addr == cca_pkg::OFF_CNT_HIGH);

  // ----------------------------------------------------------------
  // Count source
  // ----------------------------------------------------------------
  // source select decode
  assign src_sel = cca_pkg::cca_src_e'({cnt_mode_ff[cca_pkg::MODE_SRC_HI], cnt_mode_ff[cca_pkg::MODE_SRC_LO]});

  // Divide ratio follows the 6/12-clock mode
  always_comb
  begin
    case (src_sel)
      cca_pkg::CCA_SRC_OSC_SLOW: div_sel = clk_mode_12 ? cca_pkg::DIV_SLOW_12 : cca_pkg::DIV_SLOW_6;
      cca_pkg::CCA_SRC_OSC_FAST: div_sel = clk_mode_12 ? cca_pkg::DIV_FAST_12 : cca_pkg::DIV_FAST_6;
      default:                   div_sel = cca_pkg::DIV_SLOW_6;
    endcase
  end

  assign osc_tick = (presc_ff >= 4'(div_sel - 4'h1));

  // Free-running divider; it does not restart on run, so the first count may come early
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      presc_ff <= 4'h0;
    end
    else if (osc_tick)
    begin
      presc_ff <= 4'h0;
    end
    else
    begin
      presc_ff <= 4'(presc_ff + 4'h1);
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      ext_s1_ff <= cca_pkg::RST_PIN;
      ext_s2_ff <= cca_pkg::RST_PIN;
      ext_s3_ff <= cca_pkg::RST_PIN;
    end
    else
    begin
      ext_s1_ff <= p1_in[cca_pkg::PIN_EXT_COUNT];
      ext_s2_ff <= ext_s1_ff;
      ext_s3_ff <= ext_s2_ff;
    end
  end

  // Count on rising edges of the external pin
  assign ext_tick = ext_s2_ff & ~ext_s3_ff;

  always_comb
  begin
    case (src_sel)
      cca_pkg::CCA_SRC_OSC_SLOW: src_tick = osc_tick;
      cca_pkg::CCA_SRC_OSC_FAST: src_tick = osc_tick;
      cca_pkg::CCA_SRC_T0_OVF:   src_tick = timer0_ovf;
      cca_pkg::CCA_SRC_EXT_PIN:  src_tick = ext_tick;
      default:                   src_tick = 1'b0;
    endcase
  end

  // ----------------------------------------------------------------
  // Time base
  // ----------------------------------------------------------------
  // run gate
  assign count_en = run_ff & ~(cpu_idle & cnt_mode_ff[cca_pkg::MODE_IDLE_BIT]);
  assign tick     = count_en & src_tick;
  assign nxt_cnt  = cca_pkg::CNT_W'(cnt_ff + 16'h0001);
  assign ovf_set  = tick & (cnt_ff == cca_pkg::CNT_MAX);

  // shared counter; software byte writes override a count
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      cnt_ff <= '0;
    end
    else if (wr_cntl)
    begin
      cnt_ff <= {cnt_ff[15:8], bus_req.wdata};
    end
    else if (wr_cnth)
    begin
      cnt_ff <= {bus_req.wdata, cnt_ff[7:0]};
    end
    else if (tick)
    begin
      cnt_ff <= nxt_cnt;
    end
  end

  // ----------------------------------------------------------------
  // Control and flags
  // ----------------------------------------------------------------
  // Run bit, software only
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      run_ff <= 1'b0;
    end
    else if (wr_ctrl)
    begin
      run_ff <= bus_req.wdata[cca_pkg::CTRL_RUN_BIT];
    end
  end

  // Flags: hardware only sets, a set beats a same-cycle clear
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      ovf_flag_ff <= 1'b0;
      mod_flag_ff <= '0;
    end
    else if (wr_ctrl)
    begin
      ovf_flag_ff <= bus_req.wdata[cca_pkg::CTRL_OVF_BIT] | ovf_set;
      mod_flag_ff <= bus_req.wdata[cca_pkg::NUM_MOD-1:0] | mod_evt;
    end
    else
    begin
      ovf_flag_ff <= ovf_flag_ff | ovf_set;
      mod_flag_ff <= mod_flag_ff | mod_evt;
    end
  end

  // Counter mode register; reserved bits held at zero
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      cnt_mode_ff <= cca_pkg::RST_REG;
    end
    else if (wr_cmode)
    begin
      cnt_mode_ff <= {bus_req.wdata[7:6], 3'b000, bus_req.wdata[2:0]};
    end
  end

  // ----------------------------------------------------------------
  // Capture/compare modules
  // ----------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < cca_pkg::NUM_MOD; gi++)
    begin : g_mod
      logic s1_ff;      // Pin sync stage 1
      logic s2_ff;      // Pin sync stage 2
      logic s3_ff;      // Edge history
      logic cap_evt;    // Capture this cycle
      logic wr_mm;      // Write decodes
      logic wr_capl;
      logic wr_caph;
      logic pwm_mode;
      logic low_wrap;

      assign wr_mm   = bus_req.wr && (bus_req.addr == cca_pkg::ADDR_W'(cca_pkg::OFF_MM_BASE + gi));
      assign wr_capl = bus_req.wr && (bus_req.addr == cca_pkg::ADDR_W'(cca_pkg::OFF_CAPL_BASE + gi));
      assign wr_caph = bus_req.wr && (bus_req.addr == cca_pkg::ADDR_W'(cca_pkg::OFF_CAPH_BASE + gi));

      assign pwm_mode = mm_ff[gi][cca_pkg::MM_PWM] & mm_ff[gi][cca_pkg::MM_COMP_EN];
      assign low_wrap = tick & (cnt_ff[7:0] == cca_pkg::LOW_MAX);

      // Mode register
      always_ff @(posedge ref_clk or negedge arst_n)
      begin
        if (!arst_n)
        begin
          mm_ff[gi] <= cca_pkg::RST_REG;
        end
        else if (wr_mm)
        begin
          mm_ff[gi] <= {1'b0, bus_req.wdata[6:0]};
        end
      end

      always_ff @(posedge ref_clk or negedge arst_n)
      begin
        if (!arst_n)
        begin
          s1_ff <= cca_pkg::RST_PIN;
          s2_ff <= cca_pkg::RST_PIN;
          s3_ff <= cca_pkg::RST_PIN;
        end
        else
        begin
          s1_ff <= p1_in[cca_pkg::PIN_MOD_BASE + gi];
          s2_ff <= s1_ff;
          s3_ff <= s2_ff;
        end
      end

      assign cap_evt = (mm_ff[gi][cca_pkg::MM_CAP_RISE] & s2_ff & ~s3_ff) |
                       (mm_ff[gi][cca_pkg::MM_CAP_FALL] & ~s2_ff & s3_ff);

      assign mod_match[gi] = mm_ff[gi][cca_pkg::MM_COMP_EN] & tick &
                             (nxt_cnt == {caph_ff[gi], capl_ff[gi]});

      assign mod_evt[gi] = (mod_match[gi] & mm_ff[gi][cca_pkg::MM_MATCH] & ~pwm_mode) | cap_evt;
      assign mod_irq_en[gi] = mm_ff[gi][cca_pkg::MM_IRQ_EN];

      // Capture pair; hardware capture wins over a software write
      always_ff @(posedge ref_clk or negedge arst_n)
      begin
        if (!arst_n)
        begin
          capl_ff[gi] <= cca_pkg::RST_REG;
          caph_ff[gi] <= cca_pkg::RST_REG;
        end
        else if (cap_evt)
        begin
          capl_ff[gi] <= cnt_ff[7:0];
          caph_ff[gi] <= cnt_ff[15:8];
        end
        else
        begin
          // duty reload from high byte at low-byte wrap
          if (wr_capl)
          begin
            capl_ff[gi] <= bus_req.wdata;
          end
          else if (pwm_mode && low_wrap)
          begin
            capl_ff[gi] <= caph_ff[gi];
          end
          if (wr_caph)
          begin
            caph_ff[gi] <= bus_req.wdata;
          end
        end
      end

      // Pin output latch
      always_ff @(posedge ref_clk or negedge arst_n)
      begin
        if (!arst_n)
        begin
          pin_ff[gi] <= cca_pkg::RST_PIN;
        end
        else if (pwm_mode)
        begin
          // high while low byte at or above duty value
          pin_ff[gi] <= (cnt_ff[7:0] >= capl_ff[gi]);
        end
        else if (mod_match[gi] && mm_ff[gi][cca_pkg::MM_TOGGLE])
        begin
          pin_ff[gi] <= ~pin_ff[gi];
        end
      end

      // Drive only in toggle or PWM use, otherwise the pin is a capture input
      assign pin_drive[gi] = mm_ff[gi][cca_pkg::MM_COMP_EN] &
                             (mm_ff[gi][cca_pkg::MM_TOGGLE] | mm_ff[gi][cca_pkg::MM_PWM]);
    end
  endgenerate

  // port-1 mapping, other bits left undriven
  always_comb
  begin
    p1_out = '0;
    p1_oe  = '0;
    for (int i = 0; i < cca_pkg::NUM_MOD; i++)
    begin
      p1_out[cca_pkg::PIN_MOD_BASE + i] = pin_ff[i];
      p1_oe[cca_pkg::PIN_MOD_BASE + i]  = pin_drive[i];
    end
  end

  // ----------------------------------------------------------------
  // Requests
  // ----------------------------------------------------------------
  // overflow and module requests, each gated by its enable
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      irq_ff <= 1'b0;
    end
    else
    begin
      irq_ff <= (ovf_flag_ff & cnt_mode_ff[cca_pkg::MODE_OVF_IE]) | (|(mod_flag_ff & mod_irq_en));
    end
  end

  // watchdog trip from module four match
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      wdt_trip_ff <= 1'b0;
    end
    else
    begin
      wdt_trip_ff <= cnt_mode_ff[cca_pkg::MODE_WDT_BIT] & mod_match[cca_pkg::WDT_MOD];
    end
  end

  assign irq             = irq_ff;
  assign watchdog_enable = cnt_mode_ff[cca_pkg::MODE_WDT_BIT];
  assign watchdog_trip   = wdt_trip_ff;

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  // Read mux; unmapped addresses read zero
  always_comb
  begin
    nxt_rdata = '0;
    if (bus_req.addr == cca_pkg::OFF_CTRL_FLAGS)
    begin
      nxt_rdata = {ovf_flag_ff, run_ff, 1'b0, mod_flag_ff};
    end
    else if (bus_req.addr == cca_pkg::OFF_CNT_MODE)
    begin
      nxt_rdata = cnt_mode_ff;
    end
    else if (bus_req.addr == cca_pkg::OFF_CNT_LOW)
    begin
      nxt_rdata = cnt_ff[7:0];
    end
    else if (bus_req.addr == cca_pkg::OFF_CNT_HIGH)
    begin
      nxt_rdata = cnt_ff[15:8];
    end
    for (int i = 0; i < cca_pkg::NUM_MOD; i++)
    begin
      if (bus_req.addr == cca_pkg::ADDR_W'(cca_pkg::OFF_MM_BASE + i))
      begin
        nxt_rdata = mm_ff[i];
      end
      if (bus_req.addr == cca_pkg::ADDR_W'(cca_pkg::OFF_CAPL_BASE + i))
      begin
        nxt_rdata = capl_ff[i];
      end
      if (bus_req.addr == cca_pkg::ADDR_W'(cca_pkg::OFF_CAPH_BASE + i))
      begin
        nxt_rdata = caph_ff[i];
      end
    end
  end

  // Data stand only in the cycle after the read strobe
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      rdata_ff <= '0;
    end
    else if (bus_req.rd)
    begin
      rdata_ff <= nxt_rdata;
    end
    else
    begin
      rdata_ff <= '0;
    end
  end

  assign bus_rdata = rdata_ff;

endmodule

// >>> cca_top_assertions.sv
// Port-level checks of the counter array top.
// Assumes it is bound to cca_top and sees only its ports.
`timescale 1ns/1ps
module cca_checker
(
  // Clock, reset and register port
  input wire logic              ref_clk,
  input wire logic              arst_n,
  input wire cca_pkg::cca_bus_s bus_req,
  input wire logic [7:0]        bus_rdata,
  // Processor context
  input wire logic              cpu_idle,
  input wire logic              clk_mode_12,
  input wire logic              timer0_ovf,
  // Pins and requests
  input wire logic [7:0]        p1_in,
  input wire logic [7:0]        p1_out,
  input wire logic [7:0]        p1_oe,
  input wire logic              irq,
  input wire logic              watchdog_enable,
  input wire logic              watchdog_trip
);
  // ----------------------------------------------------------------
  // One clock domain, so one default clocking and disable
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!arst_n);

  a_rdata_idle: assert property (!$past(bus_req.rd) |-> bus_rdata == 8'h00)
    else $error("read data outside its cycle");
  a_low_pins: assert property (p1_oe[2:0] == 3'h0 && p1_out[2:0] == 3'h0)
    else $error("pin below module pins driven");
  a_reset_quiet: assert property ($rose(arst_n) |-> p1_out[7:3] == 5'h1F && p1_oe == 8'h00 && !irq)
    else $error("outputs not quiet after reset");
  a_wdt_follow: assert property (bus_req.wr && bus_req.addr == cca_pkg::OFF_CNT_MODE
    |=> watchdog_enable == $past(bus_req.wdata[6]))
    else $error("watchdog enable does not follow mode");
  a_trip_gated: assert property (watchdog_trip |-> $past(watchdog_enable))
    else $error("trip while watchdog off");
  a_trip_pulse: assert property (watchdog_trip |=> !watchdog_trip)
    else $error("trip longer than one cycle");
  // Undriven module pins must not move: toggles only with comparator on
  a_pin_hold: assert property (((p1_out[7:3] ^ $past(p1_out[7:3])) & ~$past(p1_oe[7:3])) == 5'h00)
    else $error("module pin moved while not driven");
  a_oe_mode: assert property (bus_req.wr && bus_req.addr[5:3] == 3'b010 && bus_req.addr[2:0] < 3'd5
    |=> p1_oe[3 + $past(bus_req.addr[2:0])] == ($past(bus_req.wdata[6]) && ($past(bus_req.wdata[2])
    || $past(bus_req.wdata[1]))))
    else $error("pin enable does not match mode");
  a_reserved_zero: assert property (bus_req.rd && bus_req.addr == cca_pkg::OFF_CNT_MODE
    |=> bus_rdata[5:3] == 3'h0)
    else $error("reserved mode bits read nonzero");
endmodule

bind cca_top cca_checker i_chk (.ref_clk, .arst_n, .bus_req, .bus_rdata, .cpu_idle, .clk_mode_12,
  .timer0_ovf, .p1_in, .p1_out, .p1_oe, .irq, .watchdog_enable, .watchdog_trip);

// >>> cca_pin_model.sv
// Far-side model of port 1: count input and capture levels.
// Assumes the bench sets cap_lvl by non-blocking assignment.
`timescale 1ns/1ps
module cca_pin_model
(
  // Clock and reset
  input wire logic       ref_clk,
  input wire logic       arst_n,
  // Bench control and device pins
  input wire logic [4:0] cap_lvl,
  input wire logic [7:0] p1_out,
  input wire logic [7:0] p1_oe,
  output logic [7:0]     p1_in
);
  logic [3:0] ph_ff;  // Free phase; count pin has an 8-cycle period

  // Free running phase, also a moving pattern for floating pins
  always_ff @(posedge ref_clk or negedge arst_n)
    if (!arst_n)
      ph_ff <= 4'h0;
    else
      ph_ff <= ph_ff + 4'h1;

  // module pins
  // Driven level wins over the outside level
  assign p1_in[7:3] = (p1_oe[7:3] & p1_out[7:3]) | (~p1_oe[7:3] & cap_lvl);
  // Count pin, and floating pins that never hold a stale value
  assign p1_in[2:0] = {ph_ff[2], ph_ff[1:0]};
endmodule

// >>> test_counter_array_capture_compare.sv
// Self-checking bench: registers, count sources, overflow, match, capture.
// Assumes cca_top, the pin model and the bound checker compile before it.
`timescale 1ns/1ps
module test_counter_array_capture_compare;
  logic              ref_clk = 1'b0, arst_n = 1'b0, rd_d = 1'b0;
  logic              cpu_idle = 1'b0, clk_mode_12 = 1'b0, timer0_ovf = 1'b0;
  logic              irq, watchdog_enable, watchdog_trip;
  cca_pkg::cca_bus_s bus_req = '0;
  logic [7:0]        bus_rdata, p1_in, p1_out, p1_oe, v;
  logic [5:0]        a;
  logic [4:0]        cap_lvl = 5'h1F;  // Module pins idle high
  logic [7:0]        exp_q[$];         // Expected read data, oldest first
  int                n_fail = 0, samples_checked = 0;
  // Mode byte, 12-clock, idle, expected count over 96 cycles
  logic [17:0]       tbl[7] = '{{8'h00, 2'b00, 8'd16}, {8'h00, 2'b10, 8'd8}, {8'h02, 2'b00, 8'd48},
    {8'h02, 2'b10, 8'd24}, {8'h06, 2'b00, 8'd12}, {8'h80, 2'b01, 8'd0}, {8'h00, 2'b01, 8'd16}};

  cca_top i_dut (.ref_clk, .arst_n, .bus_req, .bus_rdata, .cpu_idle, .clk_mode_12, .timer0_ovf,
    .p1_in, .p1_out, .p1_oe, .irq, .watchdog_enable, .watchdog_trip);
  cca_pin_model i_pins (.ref_clk, .arst_n, .cap_lvl, .p1_out, .p1_oe, .p1_in);

  initial forever #4 ref_clk = ~ref_clk;

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic end_of_test;
    if (exp_q.size() != 0) n_fail++;
    $display("compares %0d, mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  // One bus cycle, launched just after an edge, released after the next
  task automatic acc(input logic [5:0] ad, input logic [7:0] d, input logic w, input logic r);
    @(posedge ref_clk) bus_req <= '{ad, d, w, r};
    @(posedge ref_clk) bus_req <= '0;
  endtask
  task automatic wr(input logic [5:0] ad, input logic [7:0] d);
    acc(ad, d, 1'b1, 1'b0);
  endtask
  task automatic rd(input logic [5:0] ad, input logic [7:0] e);
    exp_q.push_back(e);
    acc(ad, 8'h00, 1'b0, 1'b1);
  endtask
  // Timer 0 overflow pulses, one count each
  task automatic tick(input int n);
    repeat (n)
    begin
      @(posedge ref_clk) timer0_ovf <= 1'b1;
      @(posedge ref_clk) timer0_ovf <= 1'b0;
    end
  endtask

  // Read data stands only in the cycle after the read
  always @(posedge ref_clk)
  begin
    rd_d <= bus_req.rd;
    if (rd_d === 1'b1) check(bus_rdata, exp_q.pop_front());
  end

  // Hang guard
  initial
  begin
    repeat (60000) @(posedge ref_clk);
    n_fail++;
    end_of_test();
  end

  initial
  begin
    void'($urandom(79));
    repeat (20) @(posedge ref_clk);
    arst_n <= 1'b1;
    rd(6'h00, 8'h00); rd(6'h01, 8'h00); rd(6'h3F, 8'h00);
    // Mode, capture low, capture high of every module
    for (int i = 0; i < 5; i++)
      for (int j = 2; j < 5; j++)
      begin
        a = 6'(j * 8 + i);
        v = 8'($urandom);
        rd(a, 8'h00);
        wr(a, v);
        rd(a, j == 2 ? v & 8'h7F : v);
        wr(a, 8'h00);
      end
    v = 8'($urandom);
    wr(6'h01, v);
    rd(6'h01, v & 8'hC7);
    $display("test registers done");
    // Overflow through timer 0 source, flag kept until software clears
    wr(6'h01, 8'h05); wr(6'h02, 8'hFE); wr(6'h03, 8'hFF); wr(6'h00, 8'h40);
    tick(3);
    @(posedge ref_clk) #1 check(8'(irq), 8'h01);
    rd(6'h00, 8'hC0);
    wr(6'h00, 8'h40);
    rd(6'h00, 8'h40);
    #1 check(8'(irq), 8'h00);
    $display("test overflow done");
    // Match on module 1 with toggle and flag, module 4 comparator only
    wr(6'h00, 8'h00); wr(6'h02, 8'h00); wr(6'h03, 8'h00); wr(6'h19, 8'h03); wr(6'h1C, 8'h03);
    wr(6'h11, 8'h4D); wr(6'h14, 8'h40); wr(6'h01, 8'h44);
    #1 check(p1_oe, 8'h10);
    check(8'(watchdog_enable), 8'h01);
    wr(6'h00, 8'h40);
    tick(3);
    // Trip pulse stands only in the cycle after the matching count
    #1 check(8'(watchdog_trip), 8'h01);
    check(8'(p1_out[4]), 8'h00);
    @(posedge ref_clk) #1 check(8'(irq), 8'h01);
    check(8'(watchdog_trip), 8'h00);
    rd(6'h00, 8'h42);
    wr(6'h00, 8'h00); wr(6'h11, 8'h00); wr(6'h14, 8'h00); wr(6'h01, 8'h00);
    rd(6'h00, 8'h00);
    $display("test match done");
    // Capture: module 2 on rising only, module 3 on falling only
    wr(6'h02, 8'h34); wr(6'h03, 8'h12); wr(6'h12, 8'h20); wr(6'h13, 8'h10);
    cap_lvl <= 5'h13;
    repeat (6) @(posedge ref_clk);
    wr(6'h02, 8'h78); wr(6'h03, 8'h56);
    cap_lvl <= 5'h17;
    repeat (6) @(posedge ref_clk);
    rd(6'h1A, 8'h78); rd(6'h22, 8'h56);
    rd(6'h1B, 8'h34); rd(6'h23, 8'h12);
    rd(6'h00, 8'h0C);
    wr(6'h00, 8'h00); wr(6'h12, 8'h00); wr(6'h13, 8'h00);
    $display("test capture done");
    // PWM on module 0: pin high while counter low at or above duty
    wr(6'h02, 8'h10); wr(6'h18, 8'h80); wr(6'h20, 8'h80); wr(6'h10, 8'h42);
    @(posedge ref_clk) #1 check(p1_oe, 8'h08);
    check(8'(p1_out[3]), 8'h00);
    wr(6'h02, 8'h90);
    @(posedge ref_clk) #1 check(8'(p1_out[3]), 8'h01);
    wr(6'h10, 8'h00);
    $display("test pwm done");
    // Count sources and idle stop over a 96-cycle run window
    for (int i = 0; i < 7; i++)
    begin
      wr(6'h02, 8'h00); wr(6'h03, 8'h00); wr(6'h01, tbl[i][17:10]);
      clk_mode_12 <= tbl[i][9];
      cpu_idle <= tbl[i][8];
      wr(6'h00, 8'h40);
      repeat (94) @(posedge ref_clk);
      wr(6'h00, 8'h00);
      rd(6'h02, tbl[i][7:0]);
      rd(6'h03, 8'h00);
    end
    $display("test count sources done");
    repeat (4) @(posedge ref_clk);
    end_of_test();
  end
endmodule
